// >>> tb/datmod_sources.sv
// Source model: pins and peripheral outputs feeding the modulator
module datmod_sources (
    input wire logic clk,
    input wire logic run,
    input wire logic [35:0] lv,
    output logic high_carrier_pin,
    output logic low_carrier_pin,
    output logic [15:1] carrier_periph,
    output logic modulating_pin,
    output logic [19:2] modulating_periph
);
    timeunit 1ns;
    timeprecision 1ns;

    //------------------------------------------------------------------
    // Source levels
    //------------------------------------------------------------------
    logic [2:0] div_ff = 3'h0; // Slow toggle divider
    logic [35:0] src_ff = 36'h0; // Present level of every source

    // Sources keep running while asked, else stand at the given levels
    always @(posedge clk) begin
        div_ff <= div_ff + 3'h1;
        if (run) begin
            src_ff <= lv ^ {36{div_ff[2]}};
        end else begin
            src_ff <= lv;
        end
    end

    assign high_carrier_pin = src_ff[0];
    assign low_carrier_pin = src_ff[1];
    assign carrier_periph = src_ff[16:2];
    assign modulating_pin = src_ff[17];
    assign modulating_periph = src_ff[35:18];
endmodule // datmod_sources

// >>> tb/datmod_top_test.sv
// Self-checking bench of the data signal modulator
module datmod_top_test
    import datmod_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    //------------------------------------------------------------------
    // Signals
    //------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pd = 1'b0; // Power-down request
    logic run = 1'b0; // Sources toggle when high
    logic [35:0] lv = 36'h0; // Source levels
    logic hcp;
    logic lcp;
    logic mp;
    logic outp;
    logic [15:1] cper;
    logic [19:2] mper;
    logic [7:0] rg [5]; // Mirror of register contents
    logic [7:0] msk [5] = '{8'h91, 8'h33, 8'h1f, 8'h0f, 8'h0f};
    logic [31:0] seed = 32'hd54c93d5;
    logic [31:0] q; // Last read data
    logic e; // Last error flag
    logic [31:0] r;
    int err_total = 0;
    int checks_done = 0;

    datmod_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .modulator_power_down(pd),
        .high_carrier_pin(hcp), .low_carrier_pin(lcp),
        .carrier_periph(cper), .modulating_pin(mp),
        .modulating_periph(mper), .modulated_output_pin(outp));

    datmod_sources src (.clk(clk), .run(run), .lv(lv),
        .high_carrier_pin(hcp), .low_carrier_pin(lcp),
        .carrier_periph(cper), .modulating_pin(mp),
        .modulating_periph(mper));

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected pin for standing sources, no handover pending
    function automatic logic exp_out();
        logic m;
        logic hc;
        logic lc;
        logic [4:0] s;
        s = rg[2][4:0];
        m = (s == 5'h00) ? lv[17] : (s == 5'h01) ? rg[0][0] :
            (s < 5'h14) ? lv[s + 16] : 1'b0;
        hc = (rg[4][3:0] == 4'h0) ? lv[0] : lv[rg[4][3:0] + 1];
        lc = (rg[3][3:0] == 4'h0) ? lv[1] : lv[rg[3][3:0] + 1];
        return rg[0][7] & ((m ? hc ^ rg[1][5] : lc ^ rg[1][1]) ^ rg[0][4]);
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
            input string m);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    // One APB transfer; data and error taken at the ready edge
    task automatic apb(input logic w, input logic [13:0] i,
            input logic [7:0] d);
        int n;
        logic rdy;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        rdy = 1'b0;
        while (rdy !== 1'b1 && n < 20) begin
            @(posedge clk);
            q = prdata;
            e = pslverr;
            rdy = pready;
            n++;
        end
        if (rdy !== 1'b1) begin
            err_total++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input int k, input logic [7:0] d);
        rg[k] = d & msk[k];
        apb(1'b1, IDX_CONTROL_MAIN + 14'(k), d);
    endtask

    // Wait past the source latency, then compare the pin
    task automatic pin_chk(input logic b);
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk({31'h0, outp}, {31'h0, b}, "pin level");
        @(posedge clk);
    endtask

    // Pin and every register against the mirror
    task automatic settle_chk();
        pin_chk(exp_out());
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, IDX_CONTROL_MAIN + 14'(k), 8'h00);
            chk(q, {24'h0, rg[k] | ((k == 0) ? {2'h0, exp_out(), 5'h0}
                : 8'h0)}, "register read");
            chk({31'h0, e}, 32'h0, "error flag");
        end
    endtask

    task automatic zero_rg();
        for (int k = 0; k < 5; k++) begin
            rg[k] = 8'h00;
        end
    endtask

    // Handover waits for the old carrier's falling edge
    task automatic sync_case(input logic [7:0] opt, input logic [7:0] m0,
            input logic [35:0] on);
        lv <= on;
        wr(1, opt);
        wr(2, 8'h01);
        wr(3, 8'h00);
        wr(4, 8'h00);
        wr(0, m0);
        pin_chk(1'b1);
        wr(0, m0 ^ 8'h01);
        pin_chk(1'b1);
        lv <= 36'h0;
        pin_chk(1'b0);
        lv <= on;
        pin_chk(1'b0);
        $display("test sync done");
    endtask

    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        zero_rg();
        settle_chk();
        apb(1'b0, IDX_CONTROL_MAIN - 14'h1, 8'h00);
        chk({31'h0, e}, 32'h1, "unmapped low");
        apb(1'b0, IDX_HIGH_CARRIER + 14'h1, 8'h00);
        chk({31'h0, e}, 32'h1, "unmapped high");
        chk(q, 32'h0, "unmapped data");
        wr(0, 8'h6e);
        for (int k = 1; k < 5; k++) begin
            wr(k, 8'hff);
        end
        settle_chk();
        $display("test map done");
        // Random configs over every modulating and high carrier selector code; low carrier codes random
        for (int t = 0; t < 40; t++) begin
            r = rnd();
            lv <= {r[3:0], rnd()};
            run <= 1'b1;
            wr(0, r[7:0]);
            wr(1, r[15:8] & 8'h22);
            wr(2, {3'h0, (t < 32) ? 5'(t) : r[20:16]});
            wr(3, {4'h0, 4'(t) ^ r[27:24]});
            wr(4, {4'h0, 4'(t)});
            run <= 1'b0;
            settle_chk();
        end
        $display("test random done");
        sync_case(8'h10, 8'h81, 36'h1);
        sync_case(8'h01, 8'h80, 36'h2);
        wr(0, 8'h91);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        zero_rg();
        settle_chk();
        wr(0, 8'h91);
        pd <= 1'b1;
        @(posedge clk);
        apb(1'b1, IDX_MOD_SOURCE, 8'h01);
        zero_rg();
        settle_chk();
        pd <= 1'b0;
        settle_chk();
        wr(0, 8'h10);
        settle_chk();
        $display("test reset done");
        end_of_test();
    end
endmodule // datmod_top_test

// >>> verilog/datmod_pkg.sv
// Constants, types and register map of the data signal modulator
//----------------------------------------------------------------------
// Contract
// R1: High mod mixes high carrier, low mixes low
// R2: Enable clear holds output low, keeps selections
// R3: Keeps modulating while device sleeps
// R4: Any reset disables and defaults all registers
// R5: Power-down disables; registers return to reset values
// R6: Control main bit 7 enables mixing
// R7: Control main bit 5 reads modulated output
// R8: Control main bit 4 inverts output polarity
// R9: Control main bit 0 is software modulating bit
// R10: Source code 1 software bit, 0 pin
// R11: Software bit unreliable at high signal rates
// R12: Options bit 5 inverts high carrier
// R13: Options bit 4 syncs high-to-low on falling edge
// R14: Options bit 1 inverts low carrier
// R15: Options bit 0 syncs low-to-high on falling edge
// R16: Unsynced switching may leave narrow pulses
// R17: High carrier selector, 4-bit source code
// R18: Low carrier selector, same encoding, own pin
// R19: 5-bit modulating source selector in bits 4:0
// R20: Register map at indices 0x897 to 0x89b
// R21: Reserved codes, unused bits read zero
// R22: Pending sync keeps old carrier until edge
//----------------------------------------------------------------------
package datmod_pkg;

    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_CONTROL_MAIN = 14'h0897;
    localparam logic [13:0] IDX_CARRIER_OPTIONS = 14'h0898;
    localparam logic [13:0] IDX_MOD_SOURCE = 14'h0899;
    localparam logic [13:0] IDX_LOW_CARRIER = 14'h089a;
    localparam logic [13:0] IDX_HIGH_CARRIER = 14'h089b;

    // Control main field positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_OUT = 5;
    localparam int BIT_OUTPUT_INVERT = 4;
    localparam int BIT_SW_MOD = 0;
    // Carrier options field positions
    localparam int BIT_HI_INVERT = 5;
    localparam int BIT_HI_SYNC = 4;
    localparam int BIT_LO_INVERT = 1;
    localparam int BIT_LO_SYNC = 0;

    // Selector widths and source counts
    localparam int CAR_CODE_W = 4;
    localparam int MOD_CODE_W = 5;
    localparam int NUM_CAR_SRC = 16;
    localparam int NUM_MOD_SRC = 20;
    // Modulating source codes
    localparam logic [4:0] MOD_CODE_PIN = 5'h00;
    localparam logic [4:0] MOD_CODE_SW = 5'h01;
    // Reset values
    localparam logic [4:0] RST_MOD_CODE = 5'h00;
    localparam logic [3:0] RST_CAR_CODE = 4'h0;

    // Control main fields
    typedef struct packed {
        logic enable;
        logic output_invert;
        logic software_modulating_bit;
    } datmod_main_s;

    // Carrier option fields
    typedef struct packed {
        logic high_carrier_invert;
        logic high_carrier_sync_enable;
        logic low_carrier_invert;
        logic low_carrier_sync_enable;
    } datmod_opts_s;

endpackage

// >>> verilog/datmod_top.sv
// Data signal modulator: APB registers, source muxes and carrier mixer
module datmod_top
    import datmod_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral power-down request, same clock domain
    input wire logic modulator_power_down,
    // Sources from pins and peripherals, asynchronous
    input wire logic high_carrier_pin,
    input wire logic low_carrier_pin,
    input wire logic [NUM_CAR_SRC-1:1] carrier_periph,
    input wire logic modulating_pin,
    input wire logic [NUM_MOD_SRC-1:2] modulating_periph,
    // Modulated output
    output logic modulated_output_pin
);

    //------------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------------
    localparam int RAW_W = 2 + (NUM_CAR_SRC - 1) + 1 + (NUM_MOD_SRC - 2);

    logic [RAW_W-1:0] raw_in; // All asynchronous sources
    logic [RAW_W-1:0] meta_ff; // First stage, read only by second
    logic [RAW_W-1:0] sync_ff; // Second stage, safe to use

    assign raw_in = {modulating_periph, modulating_pin, carrier_periph,
                     low_carrier_pin, high_carrier_pin};

    // Two flops per source bit
    genvar gi;
    generate
        for (gi = 0; gi < RAW_W; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= raw_in[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    // Synchronised source groups
    logic hi_pin_s; // High carrier pin
    logic lo_pin_s; // Low carrier pin
    logic [NUM_CAR_SRC-1:1] car_per_s; // Shared carrier sources
    logic mod_pin_s; // Modulating pin
    logic [NUM_MOD_SRC-1:2] mod_per_s; // Peripheral modulating sources

    assign hi_pin_s = sync_ff[0];
    assign lo_pin_s = sync_ff[1];
    assign car_per_s = sync_ff[NUM_CAR_SRC:2];
    assign mod_pin_s = sync_ff[NUM_CAR_SRC+1];
    assign mod_per_s = sync_ff[RAW_W-1:NUM_CAR_SRC+2];

    //------------------------------------------------------------------
    // Registers
    //------------------------------------------------------------------
    datmod_main_s main_ff; // Control main fields
    datmod_opts_s opts_ff; // Carrier option fields
    logic [MOD_CODE_W-1:0] mod_code_ff; // Modulating source code
    logic [CAR_CODE_W-1:0] lo_code_ff; // Low carrier source code
    logic [CAR_CODE_W-1:0] hi_code_ff; // High carrier source code
    logic out_ff; // Modulated output

    logic clear_all; // Reset or power-down
    logic setup_ph; // APB setup cycle
    logic wr_acc; // APB write access edge
    logic addr_ok; // Word aligned
    logic hit_main, hit_opts, hit_src, hit_lo, hit_hi; // Decodes

    assign clear_all = rst | modulator_power_down; // R4 R5
    assign setup_ph = psel & ~penable;
    assign addr_ok = (paddr[1:0] == 2'b00);
    assign hit_main = addr_ok && (paddr[15:2] == IDX_CONTROL_MAIN); // R20
    assign hit_opts = addr_ok && (paddr[15:2] == IDX_CARRIER_OPTIONS);
    assign hit_src = addr_ok && (paddr[15:2] == IDX_MOD_SOURCE);
    assign hit_lo = addr_ok && (paddr[15:2] == IDX_LOW_CARRIER);
    assign hit_hi = addr_ok && (paddr[15:2] == IDX_HIGH_CARRIER);
    // Writes ignored while powered down
    assign wr_acc = psel & penable & pwrite & ~modulator_power_down;

    // Control main register
    always_ff @(posedge clk) begin
        if (clear_all) begin
            main_ff <= '0; // R4 R5
        end else if (wr_acc && hit_main) begin
            main_ff.enable <= pwdata[BIT_ENABLE]; // R6
            main_ff.output_invert <= pwdata[BIT_OUTPUT_INVERT]; // R8
            main_ff.software_modulating_bit <= pwdata[BIT_SW_MOD]; // R9
        end
    end

    // Carrier options register
    always_ff @(posedge clk) begin
        if (clear_all) begin
            opts_ff <= '0; // R4 R5
        end else if (wr_acc && hit_opts) begin
            opts_ff.high_carrier_invert <= pwdata[BIT_HI_INVERT];
            opts_ff.high_carrier_sync_enable <= pwdata[BIT_HI_SYNC];
            opts_ff.low_carrier_invert <= pwdata[BIT_LO_INVERT];
            opts_ff.low_carrier_sync_enable <= pwdata[BIT_LO_SYNC];
        end
    end

    // Source selector registers; enable clear keeps them
    always_ff @(posedge clk) begin
        if (clear_all) begin
            mod_code_ff <= RST_MOD_CODE; // R4 R5
            lo_code_ff <= RST_CAR_CODE;
            hi_code_ff <= RST_CAR_CODE;
        end else begin
            if (wr_acc && hit_src) begin
                mod_code_ff <= pwdata[MOD_CODE_W-1:0]; // R19
            end
            if (wr_acc && hit_lo) begin
                lo_code_ff <= pwdata[CAR_CODE_W-1:0]; // R18
            end
            if (wr_acc && hit_hi) begin
                hi_code_ff <= pwdata[CAR_CODE_W-1:0]; // R17
            end
        end
    end

    //------------------------------------------------------------------
    // APB read path
    //------------------------------------------------------------------
    logic [31:0] nxt_rdata; // Read value in setup cycle
    logic [31:0] rdata_ff; // Registered read data
    logic err_ff; // Registered slave error

    // Read mux; unused bits are zero
    always_comb begin
        nxt_rdata = 32'h0000_0000; // R21
        if (!modulator_power_down) begin
            if (hit_main) begin
                nxt_rdata[BIT_ENABLE] = main_ff.enable;
                nxt_rdata[BIT_OUT] = out_ff; // R7
                nxt_rdata[BIT_OUTPUT_INVERT] = main_ff.output_invert;
                nxt_rdata[BIT_SW_MOD] = main_ff.software_modulating_bit;
            end else if (hit_opts) begin
                nxt_rdata[BIT_HI_INVERT] = opts_ff.high_carrier_invert;
                nxt_rdata[BIT_HI_SYNC] = opts_ff.high_carrier_sync_enable;
                nxt_rdata[BIT_LO_INVERT] = opts_ff.low_carrier_invert;
                nxt_rdata[BIT_LO_SYNC] = opts_ff.low_carrier_sync_enable;
            end else if (hit_src) begin
                nxt_rdata[MOD_CODE_W-1:0] = mod_code_ff;
            end else if (hit_lo) begin
                nxt_rdata[CAR_CODE_W-1:0] = lo_code_ff;
            end else if (hit_hi) begin
                nxt_rdata[CAR_CODE_W-1:0] = hi_code_ff;
            end
        end
    end

    // Capture read data and error in the setup cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
        end else if (setup_ph) begin
            rdata_ff <= nxt_rdata;
            err_ff <= ~(hit_main | hit_opts | hit_src | hit_lo | hit_hi);
        end
    end

    assign prdata = rdata_ff;
    assign pready = 1'b1; // Zero wait states
    assign pslverr = psel & penable & err_ff;

    //------------------------------------------------------------------
    // Source selection and polarity
    //------------------------------------------------------------------
    logic [NUM_CAR_SRC-1:0] hi_bank, lo_bank; // Carrier candidates
    logic hi_car, lo_car; // Selected, polarity applied
    logic mod_val; // Selected modulating signal

    assign hi_bank = {car_per_s, hi_pin_s};
    assign lo_bank = {car_per_s, lo_pin_s}; // R18
    // R12 R17
    assign hi_car = hi_bank[hi_code_ff] ^ opts_ff.high_carrier_invert;
    // R14 R18
    assign lo_car = lo_bank[lo_code_ff] ^ opts_ff.low_carrier_invert;

    // Modulating source mux
    always_comb begin
        if (mod_code_ff == MOD_CODE_PIN) begin
            mod_val = mod_pin_s; // R10
        end else if (mod_code_ff == MOD_CODE_SW) begin
            mod_val = main_ff.software_modulating_bit; // R9 R10
        end else if (mod_code_ff < MOD_CODE_W'(NUM_MOD_SRC)) begin
            mod_val = mod_per_s[mod_code_ff]; // R19
        end else begin
            mod_val = 1'b0; // R21
        end
    end

    //------------------------------------------------------------------
    // Carrier switch with optional synchronisation
    //------------------------------------------------------------------
    logic sel_hi_ff; // Carrier currently mixed is high
    logic hi_prev_ff, lo_prev_ff; // Previous carrier levels
    logic hi_fall, lo_fall; // Falling edges this cycle
    logic nxt_sel_hi; // Carrier mixed this cycle

    // Edges are judged at clock rate; faster carriers alias
    assign hi_fall = hi_prev_ff & ~hi_car;
    assign lo_fall = lo_prev_ff & ~lo_car;

    // Switch now, or hold the old carrier until its falling edge
    always_comb begin
        nxt_sel_hi = sel_hi_ff;
        if (mod_val && !sel_hi_ff) begin
            if (!opts_ff.low_carrier_sync_enable || lo_fall) begin
                nxt_sel_hi = 1'b1; // R15 R16 R22
            end
        end else if (!mod_val && sel_hi_ff) begin
            if (!opts_ff.high_carrier_sync_enable || hi_fall) begin
                nxt_sel_hi = 1'b0; // R13 R16 R22
            end
        end
    end

    // Carrier history and active selection; runs in sleep too
    always_ff @(posedge clk) begin // R3
        if (clear_all) begin
            sel_hi_ff <= 1'b0;
            hi_prev_ff <= 1'b0;
            lo_prev_ff <= 1'b0;
        end else begin
            sel_hi_ff <= nxt_sel_hi;
            hi_prev_ff <= hi_car;
            lo_prev_ff <= lo_car;
        end
    end

    // Mix, invert, and gate by enable
    always_ff @(posedge clk) begin
        if (clear_all) begin
            out_ff <= 1'b0; // R4 R5
        end else if (!main_ff.enable) begin
            out_ff <= 1'b0; // R2 R6
        end else begin
            // R1 R8
            out_ff <= (nxt_sel_hi ? hi_car : lo_car) ^ main_ff.output_invert;
        end
    end

    assign modulated_output_pin = out_ff;

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_disable_low: assert property ( // R2
        !main_ff.enable |=> !out_ff)
        else $error("output not low while disabled");
    chk_mix_select: assert property ( // R1
        main_ff.enable && !modulator_power_down |=>
        out_ff == ($past(nxt_sel_hi) ? $past(hi_car) : $past(lo_car))
                  ^ $past(main_ff.output_invert))
        else $error("mixed output wrong");
    chk_out_readback: assert property ( // R7
        setup_ph && hit_main && !modulator_power_down |=>
        prdata[BIT_OUT] == $past(out_ff))
        else $error("output readback wrong");
    chk_hi_sync_hold: assert property ( // R13
        opts_ff.high_carrier_sync_enable && sel_hi_ff && !mod_val
        && !hi_fall && !modulator_power_down |=> sel_hi_ff)
        else $error("high carrier left before falling edge");
    chk_lo_sync_hold: assert property ( // R15
        opts_ff.low_carrier_sync_enable && !sel_hi_ff && mod_val
        && !lo_fall && !modulator_power_down |=> !sel_hi_ff)
        else $error("low carrier left before falling edge");
    chk_nosync_follow: assert property ( // R16
        !opts_ff.high_carrier_sync_enable && !opts_ff.low_carrier_sync_enable
        && !modulator_power_down |=> sel_hi_ff == $past(mod_val))
        else $error("unsynced switch not immediate");
    chk_reserved_low: assert property ( // R21
        mod_code_ff >= MOD_CODE_W'(NUM_MOD_SRC) |-> !mod_val)
        else $error("reserved source not low");
    chk_soft_bit: assert property ( // R10
        mod_code_ff == MOD_CODE_SW |->
        mod_val == main_ff.software_modulating_bit)
        else $error("software bit not routed");
    chk_pd_clear: assert property ( // R5
        modulator_power_down |=> main_ff == '0 && opts_ff == '0
        && mod_code_ff == RST_MOD_CODE && !out_ff)
        else $error("power-down did not clear");
    chk_hi_invert: assert property ( // R12
        opts_ff.high_carrier_invert |-> hi_car != hi_bank[hi_code_ff])
        else $error("high carrier not inverted");

    // Carrier polarity and register side
    chk_lo_invert: assert property ( // R14
        opts_ff.low_carrier_invert |-> lo_car != lo_bank[lo_code_ff])
        else $error("low carrier not inverted");
    // Selections survive a cleared enable
    chk_keep_select: assert property ( // R2
        !main_ff.enable && !wr_acc && !modulator_power_down |=>
        $stable(mod_code_ff) && $stable(lo_code_ff) && $stable(hi_code_ff))
        else $error("selection lost while disabled");
    chk_soft_readback: assert property ( // R9
        setup_ph && hit_main && !modulator_power_down |=>
        prdata[BIT_SW_MOD] == $past(main_ff.software_modulating_bit))
        else $error("software bit readback wrong");
    // Read bits 31:8 and 6, unused in every register, stay zero
    chk_unused_zero: assert property ( // R21
        setup_ph |=> prdata[31:8] == 24'h0 && prdata[6] == 1'b0)
        else $error("unused read bits not zero");
    // Reset is checked while it is asserted, so no disable here
    chk_rst_clear: assert property (disable iff (1'b0) // R4
        rst |=> main_ff == '0 && opts_ff == '0 && !out_ff
        && mod_code_ff == RST_MOD_CODE && lo_code_ff == RST_CAR_CODE
        && hi_code_ff == RST_CAR_CODE)
        else $error("reset did not clear");

    // Main scenarios
    cov_hi_sync_wait: cover property (
        opts_ff.high_carrier_sync_enable && sel_hi_ff && !mod_val ##1
        sel_hi_ff ##1 !sel_hi_ff);
    cov_lo_sync_wait: cover property (
        opts_ff.low_carrier_sync_enable && !sel_hi_ff && mod_val ##1
        !sel_hi_ff ##1 sel_hi_ff);
    cov_inverted_out: cover property (
        main_ff.enable && main_ff.output_invert && out_ff);
    cov_power_down: cover property (main_ff.enable ##1 modulator_power_down);
    cov_enable_resume: cover property (!main_ff.enable ##1 main_ff.enable);

endmodule // datmod_top
